/* haptic_trigger_defines.vh */
// register offsets, field positions, mode codes and timing constants
// for the playback trigger and waveform offset bank; definitions only
`ifndef HAPTIC_TRIGGER_DEFINES_VH
`define HAPTIC_TRIGGER_DEFINES_VH

// register byte offsets
`define ADDR_MODE 8'h01
`define ADDR_SLOT_FIRST 8'h04
`define ADDR_SLOT_LAST 8'h0b
`define ADDR_TRIGGER 8'h0c
`define ADDR_OVERDRIVE 8'h0d
`define ADDR_POS_SUSTAIN 8'h0e
`define ADDR_NEG_SUSTAIN 8'h0f

// reset values
`define RST_BYTE 8'h00
`define RST_MODE 3'h0

// field layout
`define TRIGGER_BIT 0
`define MODE_MSB 2
`define SLOT_WAIT_BIT 7
`define SLOT_VALUE_MSB 6
`define SLOT_COUNT 8
`define SLOT_IDX_LAST 3'h7
`define SLOT_IDX_FIRST 3'h0
`define SLOT_EMPTY 8'h00

// mode field encodings
`define MODE_INTERNAL 3'h0
`define MODE_EXT_EDGE 3'h1
`define MODE_EXT_LEVEL 3'h2
`define MODE_DIAG 3'h6
`define MODE_CAL 3'h7

// sample classes on the offset output
`define KIND_NONE 2'h0
`define KIND_OVERDRIVE 2'h1
`define KIND_POS_SUSTAIN 2'h2

// timing: one wait unit of a slot, and the clock rate
`define WAIT_UNIT_MS 10
`define CLK_KHZ 20000
`define WAIT_UNIT_CYCLES (`WAIT_UNIT_MS * `CLK_KHZ)

`endif

/* haptic_playback_trigger_offsets.v */
// trigger register, sequencer slots, mode register and time offset bank
// assumes a serial bus front end that delivers decoded single-byte
// register reads and writes, and a playback engine that reports done
//
// Operation
// - setting the trigger bit starts the process picked by the mode field
// - sequence playback runs slot identifiers from the first to last slot
// - trigger bit reads one during playback, hardware clears it when done
// - host writing trigger zero during playback aborts the remaining slots
// - external edge mode sets, and level mode sets or clears, the trigger bit from the pin
// - calibration or diagnostic mode starts that routine instead of playback
// - maximum-voltage sample is overdrive; its duration takes the offset
// - overdrive offset applies only open loop; closed loop ignores it
// - overdrive offset is signed, scaled by the step period in ms
// - other positive samples are positive sustain and take its offset
// - positive sustain offset is signed, scaled by the step period in ms
// - sequencer stops at the first zero slot or after all eight
`include "haptic_trigger_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module haptic_playback_trigger_offsets #(
  parameter [17:0] WAIT_CYCLES = `WAIT_UNIT_CYCLES,
  parameter [3:0] STEP_MS_SLOW = 4'h5,
  parameter [3:0] STEP_MS_FAST = 4'h1
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register access from the serial bus front end
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // device configuration
  input wire step_period_setting,
  input wire open_loop,
  input wire trig_in,
  // playback engine
  output reg wave_start,
  output reg [6:0] wave_id,
  output reg wave_abort,
  input wire wave_done,
  // calibration and diagnostic routines
  output reg cal_start,
  output reg diag_start,
  input wire routine_done,
  output wire busy,
  // library sample classification and time offset
  input wire sample_valid,
  input wire [7:0] sample_value,
  input wire [7:0] wave_peak,
  output reg adj_valid,
  output reg [1:0] adj_kind,
  output reg [11:0] adj_ms
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_FETCH = 5'h02;
  localparam [4:0] ST_PLAY = 5'h04;
  localparam [4:0] ST_DELAY = 5'h08;
  localparam [4:0] ST_ROUTINE = 5'h10;

  reg [7:0] slot_reg [0:`SLOT_COUNT-1];
  reg [`MODE_MSB:0] mode_reg;
  reg go_reg;
  reg go_next;
  reg [7:0] overdrive_time_adjust_reg;
  reg [7:0] positive_sustain_adjust_reg;
  reg [7:0] negative_sustain_adjust_reg;
  reg trig_in_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [2:0] idx_reg;
  reg [6:0] units_reg;
  reg [17:0] tick_reg;
  reg seq_done;
  wire [7:0] cur_slot;
  wire trig_rise;
  wire wr_trigger;
  wire [3:0] step_ms;
  wire [11:0] od_ms;
  wire [11:0] sp_ms;

  assign cur_slot = slot_reg[idx_reg];
  assign trig_rise = trig_in & ~trig_in_reg;
  assign wr_trigger = reg_wr && (reg_addr == `ADDR_TRIGGER);
  assign busy = (state_reg != ST_IDLE);
  assign step_ms = step_period_setting ? STEP_MS_FAST : STEP_MS_SLOW;
  assign od_ms = $signed({{4{overdrive_time_adjust_reg[7]}},
                          overdrive_time_adjust_reg}) *
                 $signed({8'h00, step_ms});
  assign sp_ms = $signed({{4{positive_sustain_adjust_reg[7]}},
                          positive_sustain_adjust_reg}) *
                 $signed({8'h00, step_ms});

  // sequencer slots, one generate entry per slot
  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : slots
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          slot_reg[g] <= `RST_BYTE;
        end else if (reg_wr &&
                     ({24'h000000, reg_addr} == `ADDR_SLOT_FIRST + g)) begin
          slot_reg[g] <= reg_wdata;
        end
      end
    end
  endgenerate

  // plain byte registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `RST_MODE;
      overdrive_time_adjust_reg <= `RST_BYTE;
      positive_sustain_adjust_reg <= `RST_BYTE;
      negative_sustain_adjust_reg <= `RST_BYTE;
      trig_in_reg <= 1'b0;
    end else begin
      trig_in_reg <= trig_in;
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_MODE: begin
            mode_reg <= reg_wdata[`MODE_MSB:0];
          end
          `ADDR_OVERDRIVE: begin
            overdrive_time_adjust_reg <= reg_wdata;
          end
          `ADDR_POS_SUSTAIN: begin
            positive_sustain_adjust_reg <= reg_wdata;
          end
          `ADDR_NEG_SUSTAIN: begin
            negative_sustain_adjust_reg <= reg_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // trigger bit: completion clears lowest, host write next, and a pin
  // set beats a host clear in the same cycle so no trigger is lost
  always @* begin
    go_next = go_reg;
    if (seq_done) begin
      go_next = 1'b0;
    end
    if (wr_trigger) begin
      go_next = reg_wdata[`TRIGGER_BIT];
    end
    if (mode_reg == `MODE_EXT_EDGE && trig_rise) begin
      go_next = 1'b1;
    end
    if (mode_reg == `MODE_EXT_LEVEL && trig_in != trig_in_reg) begin
      go_next = trig_in;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= go_next;
    end
  end

  // sequencer and process dispatch
  always @* begin
    state_next = state_reg;
    seq_done = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (go_reg) begin
          if (mode_reg == `MODE_CAL || mode_reg == `MODE_DIAG) begin
            state_next = ST_ROUTINE;
          end else begin
            state_next = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        if (cur_slot == `SLOT_EMPTY) begin
          seq_done = 1'b1;
          state_next = ST_IDLE;
        end else if (cur_slot[`SLOT_WAIT_BIT]) begin
          state_next = ST_DELAY;
        end else begin
          state_next = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (wave_done) begin
          if (idx_reg == `SLOT_IDX_LAST) begin
            seq_done = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_FETCH;
          end
        end
      end
      ST_DELAY: begin
        if (units_reg == 7'h00) begin
          if (idx_reg == `SLOT_IDX_LAST) begin
            seq_done = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_FETCH;
          end
        end
      end
      ST_ROUTINE: begin
        if (routine_done) begin
          seq_done = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // a trigger bit gone low while running cancels what is left
    if (!go_reg && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
      seq_done = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      idx_reg <= `SLOT_IDX_FIRST;
      units_reg <= 7'h00;
      tick_reg <= 18'h00000;
      wave_start <= 1'b0;
      wave_id <= 7'h00;
      wave_abort <= 1'b0;
      cal_start <= 1'b0;
      diag_start <= 1'b0;
    end else begin
      state_reg <= state_next;
      wave_start <= 1'b0;
      cal_start <= 1'b0;
      diag_start <= 1'b0;
      wave_abort <= !go_reg && (state_reg == ST_PLAY);
      if (state_reg == ST_IDLE) begin
        idx_reg <= `SLOT_IDX_FIRST;
        if (state_next == ST_ROUTINE) begin
          cal_start <= (mode_reg == `MODE_CAL);
          diag_start <= (mode_reg == `MODE_DIAG);
        end
      end
      if (state_reg == ST_FETCH && state_next == ST_PLAY) begin
        wave_start <= 1'b1;
        wave_id <= cur_slot[`SLOT_VALUE_MSB:0];
      end
      if (state_reg == ST_FETCH && state_next == ST_DELAY) begin
        units_reg <= cur_slot[`SLOT_VALUE_MSB:0];
        tick_reg <= 18'h00000;
      end
      if (state_reg == ST_DELAY && units_reg != 7'h00) begin
        if (tick_reg == WAIT_CYCLES - 18'h00001) begin
          tick_reg <= 18'h00000;
          units_reg <= units_reg - 7'h01;
        end else begin
          tick_reg <= tick_reg + 18'h00001;
        end
      end
      // step to the next slot after a waveform or a wait ends
      if ((state_reg == ST_PLAY || state_reg == ST_DELAY) &&
          state_next == ST_FETCH) begin
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // sample classification; the peak comes from the engine's library scan
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adj_valid <= 1'b0;
      adj_kind <= `KIND_NONE;
      adj_ms <= 12'h000;
    end else begin
      adj_valid <= sample_valid;
      if (sample_valid) begin
        if (sample_value == wave_peak) begin
          adj_kind <= `KIND_OVERDRIVE;
          adj_ms <= open_loop ? od_ms : 12'h000;
        end else if (!sample_value[7] && sample_value != `RST_BYTE) begin
          adj_kind <= `KIND_POS_SUSTAIN;
          adj_ms <= sp_ms;
        end else begin
          adj_kind <= `KIND_NONE;
          adj_ms <= 12'h000;
        end
      end
    end
  end

  // read port; unmapped offsets and reserved bits read zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      if (reg_addr >= `ADDR_SLOT_FIRST && reg_addr <= `ADDR_SLOT_LAST) begin
        reg_rdata <= slot_reg[reg_addr[2:0] - 3'h4];
      end else begin
        case (reg_addr)
          `ADDR_MODE: begin
            reg_rdata <= {5'h00, mode_reg};
          end
          `ADDR_TRIGGER: begin
            reg_rdata <= {7'h00, go_reg};
          end
          `ADDR_OVERDRIVE: begin
            reg_rdata <= overdrive_time_adjust_reg;
          end
          `ADDR_POS_SUSTAIN: begin
            reg_rdata <= positive_sustain_adjust_reg;
          end
          `ADDR_NEG_SUSTAIN: begin
            reg_rdata <= negative_sustain_adjust_reg;
          end
          default: begin
            reg_rdata <= `RST_BYTE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* haptic_playback_trigger_offsets_checker.sv */
// port assertions for the trigger and offset bank
// bound to every instance of the bank; one clock domain
`timescale 1ns/100ps
`default_nettype none
module haptic_bank_checker (
  input wire logic mclk, rst_n, reg_wr, reg_rd, open_loop,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic wave_start, wave_abort, cal_start, diag_start, busy,
  input wire logic sample_valid, adj_valid,
  input wire logic [7:0] sample_value, wave_peak,
  input wire logic [1:0] adj_kind,
  input wire logic [11:0] adj_ms
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire go_wr = reg_wr && reg_addr == 8'h0c && reg_wdata[0];
  wire pk = sample_valid && sample_value == wave_peak;
  wire pos = sample_valid && !pk && !sample_value[7] && |sample_value;
  a_go_busy: assert property (go_wr && !busy |-> ##2 busy)
    else $error("no busy after trigger");
  a_trig_rsvd: assert property (reg_rd && reg_addr == 8'h0c |=>
    reg_rdata[7:1] == 7'h00) else $error("reserved trigger bits set");
  a_one_routine: assert property
    ($onehot0({wave_start, cal_start, diag_start}))
    else $error("two processes started");
  a_start_run: assert property (wave_start |-> busy ##1 !wave_start)
    else $error("start not a pulse inside a run");
  a_abort_idle: assert property (wave_abort |-> !busy)
    else $error("abort left sequencer busy");
  a_adj_pulse: assert property (sample_valid |=> adj_valid)
    else $error("adjust result late");
  a_closed_od: assert property (pk && !open_loop |=>
    adj_kind == 2'h1 && adj_ms == 12'h000)
    else $error("closed loop overdrive offset used");
  a_pos_sustain: assert property (pos |=> adj_kind == 2'h2)
    else $error("positive sample not sustain");
  a_other_class: assert property (sample_valid && !pk && !pos |=>
    adj_kind == 2'h0 && adj_ms == 12'h000) else $error("bad class");
  c_abort: cover property (wave_abort);
  c_cal: cover property (cal_start);
  c_open_od: cover property (pk && open_loop);
endmodule
bind haptic_playback_trigger_offsets haptic_bank_checker chk_u (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .open_loop(open_loop), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .wave_start(wave_start), .wave_abort(wave_abort),
  .cal_start(cal_start), .diag_start(diag_start), .busy(busy),
  .sample_valid(sample_valid), .adj_valid(adj_valid),
  .sample_value(sample_value), .wave_peak(wave_peak),
  .adj_kind(adj_kind), .adj_ms(adj_ms));
`default_nettype wire

/* haptic_engine_model.sv */
// playback engine and routine model on the far side of the bank
// answers every start after DLY cycles; an abort kills the answer
`timescale 1ns/100ps
`default_nettype none
module haptic_engine_model #(parameter int DLY = 8) (
  input wire logic mclk, rst_n, wave_start, wave_abort,
  input wire logic cal_start, diag_start,
  output logic wave_done, routine_done
);
  logic [7:0] cnt_reg;
  logic rout_reg;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      rout_reg <= 1'b0;
      wave_done <= 1'b0;
      routine_done <= 1'b0;
    end else begin
      wave_done <= cnt_reg == 8'h01 && !rout_reg;
      routine_done <= cnt_reg == 8'h01 && rout_reg;
      if (wave_abort) begin
        cnt_reg <= 8'h00;
      end else if (wave_start || cal_start || diag_start) begin
        cnt_reg <= 8'(DLY);
        rout_reg <= !wave_start;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* haptic_playback_trigger_offsets_tb_top.sv */
// self-checking bench for the trigger and offset bank
// drives the decoded byte bus and sample port; engine model answers
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module haptic_playback_trigger_offsets_tb_top;
  typedef struct {logic o, s; logic [7:0] v, p; logic [1:0] k;
    logic [11:0] m;} row_t;
  // offsets are od=-2, sp=3; slow step 5 ms, fast 1 ms
  row_t rows[7] = '{'{1'b1, 1'b0, 8'h40, 8'h40, 2'h1, 12'hff6},
    '{1'b1, 1'b1, 8'h40, 8'h40, 2'h1, 12'hffe},
    '{1'b0, 1'b0, 8'h40, 8'h40, 2'h1, 12'h000},
    '{1'b1, 1'b0, 8'h20, 8'h40, 2'h2, 12'h00f},
    '{1'b0, 1'b1, 8'h20, 8'h40, 2'h2, 12'h003},
    '{1'b1, 1'b0, 8'hf0, 8'h40, 2'h0, 12'h000},
    '{1'b1, 1'b0, 8'h00, 8'h40, 2'h0, 12'h000}};
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, stp = 0, ol = 0;
  logic trig_in = 0, sv = 0;
  logic [7:0] addr = 0, wd = 0, val = 0, peak = 0, q, md;
  logic [7:0] reg_rdata;
  logic [6:0] wave_id;
  logic [1:0] adj_kind;
  logic [11:0] adj_ms;
  logic wave_start, wave_abort, cal_start, diag_start, busy;
  logic wave_done, routine_done, adj_valid;
  int n_mismatch = 0, n_tests = 0, n_abort = 0, n_cal = 0, n_diag = 0;
  logic [6:0] ids[$];
  always #25 mclk = ~mclk;
  haptic_playback_trigger_offsets #(.WAIT_CYCLES(18'd4)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(reg_rdata),
    .step_period_setting(stp), .open_loop(ol), .trig_in(trig_in),
    .wave_start(wave_start), .wave_id(wave_id), .wave_abort(wave_abort),
    .wave_done(wave_done), .cal_start(cal_start),
    .diag_start(diag_start), .routine_done(routine_done), .busy(busy),
    .sample_valid(sv), .sample_value(val), .wave_peak(peak),
    .adj_valid(adj_valid), .adj_kind(adj_kind), .adj_ms(adj_ms));
  haptic_engine_model eng_u (.mclk(mclk), .rst_n(rst_n),
    .wave_start(wave_start), .wave_abort(wave_abort),
    .cal_start(cal_start), .diag_start(diag_start),
    .wave_done(wave_done), .routine_done(routine_done));
  always @(posedge mclk) begin
    if (wave_start === 1'b1) ids.push_back(wave_id);
    if (wave_abort === 1'b1) n_abort++;
    if (cal_start === 1'b1) n_cal++;
    if (diag_start === 1'b1) n_diag++;
  end
  task wr(input logic [7:0] a, d);
    @(posedge mclk);
    #2;
    reg_wr = 1;
    addr = a;
    wd = d;
    @(posedge mclk);
    #2;
    reg_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    #2;
    reg_rd = 1;
    addr = a;
    @(posedge mclk);
    #2;
    reg_rd = 0;
    q = reg_rdata;
  endtask
  // bounded wait so a stuck sequencer shows as a mismatch, not a hang
  // the sequencer leaves idle two edges after the trigger write
  task idle;
    repeat (2) @(posedge mclk);
    #2;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #2;
    end
    `CHK(busy, 1'b0)
  endtask
  task stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    #2;
    rst_n = 1;
    rd(8'h0c);
    `CHK(q, 8'h00)
    rd(8'h0d);
    `CHK(q, 8'h00)
    wr(8'h20, 8'h55);
    rd(8'h20);
    `CHK(q, 8'h00)
    wr(8'h0c, 8'hfe);
    rd(8'h0c);
    `CHK(q, 8'h00)
    wr(8'h0d, 8'hfe);
    wr(8'h0e, 8'h03);
    rd(8'h0e);
    `CHK(q, 8'h03)
    foreach (rows[i]) begin
      @(posedge mclk);
      #2;
      {ol, stp, val, peak} = {rows[i].o, rows[i].s, rows[i].v, rows[i].p};
      sv = 1;
      @(posedge mclk);
      #2;
      sv = 0;
      `CHK(adj_valid, 1'b1)
      @(posedge mclk);
      #2;
      `CHK(adj_kind, rows[i].k)
      `CHK(adj_ms, rows[i].m)
    end
    wr(8'h04, 8'h03);
    wr(8'h05, 8'h05);
    wr(8'h06, 8'h00);
    ids.delete();
    wr(8'h0c, 8'h01);
    rd(8'h0c);
    `CHK(q, 8'h01)
    idle();
    rd(8'h0c);
    `CHK(q, 8'h00)
    `CHK(ids.size(), 2)
    `CHK(ids[1], 7'h05)
    rd(8'h05);
    `CHK(q, 8'h05)
    for (int i = 0; i < 8; i++) wr(8'h04 + 8'(i), 8'(i + 1));
    ids.delete();
    wr(8'h0c, 8'h01);
    idle();
    `CHK(ids.size(), 8)
    `CHK(ids[7], 7'h08)
    ids.delete();
    wr(8'h0c, 8'h01);
    repeat (4) @(posedge mclk);
    wr(8'h0c, 8'h00);
    repeat (2) @(posedge mclk);
    #2;
    `CHK(n_abort, 1)
    `CHK(busy, 1'b0)
    `CHK(ids.size(), 1)
    wr(8'h04, 8'h82);
    wr(8'h06, 8'h00);
    ids.delete();
    wr(8'h0c, 8'h01);
    idle();
    `CHK(ids.size(), 1)
    `CHK(ids[0], 7'h02)
    ids.delete();
    for (md = 8'h06; md < 8'h08; md++) begin
      wr(8'h01, md);
      rd(8'h01);
      `CHK(q, md)
      wr(8'h0c, 8'h01);
      rd(8'h0c);
      `CHK(q, 8'h01)
      idle();
    end
    `CHK(n_cal, 1)
    `CHK(n_diag, 1)
    `CHK(ids.size(), 0)
    wr(8'h01, 8'h01);
    trig_in = 1;
    repeat (3) @(posedge mclk);
    #2;
    `CHK(busy, 1'b1)
    wr(8'h0c, 8'h00);
    trig_in = 0;
    wr(8'h01, 8'h02);
    trig_in = 1;
    repeat (3) @(posedge mclk);
    #2;
    `CHK(busy, 1'b1)
    trig_in = 0;
    repeat (3) @(posedge mclk);
    #2;
    `CHK(busy, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire
